/* File: design/amfc_pkg.sv */
// shared constants and types for the auxiliary measurement controller
package amfc_pkg;
   // register byte offsets (32-bit aligned words)
   localparam logic [7:0] REG_CONVERTER_CTRL = 8'h00;
   localparam logic [7:0] REG_BUFFER_CTRL    = 8'h04;
   localparam logic [7:0] REG_MEAS_CONFIG    = 8'h08;
   localparam logic [7:0] REG_THRESH_LIMITS  = 8'h0C;
   localparam logic [7:0] REG_INTERVAL       = 8'h10;
   localparam logic [7:0] REG_SUPPLY_RESULT  = 8'h14;
   localparam logic [7:0] REG_EXTRA1_RESULT  = 8'h18;
   localparam logic [7:0] REG_EXTRA2_RESULT  = 8'h1C;
   localparam logic [7:0] REG_THERM1_RESULT  = 8'h20;
   localparam logic [7:0] REG_THERM2_RESULT  = 8'h24;
   localparam logic [7:0] REG_FIFO_DATA      = 8'h28;
   localparam logic [7:0] REG_START          = 8'h2C;
   // converter control fields
   localparam int SEQ_LSB  = 0;
   localparam int RES_LSB  = 4;
   localparam int RMODE_LSB = 6;
   // buffer control fields
   localparam int BUF_EN_BIT    = 0;
   localparam int BUF_CONT_BIT  = 1;
   localparam int BUF_RESET_BIT = 2;
   localparam int TRIG_LSB      = 8;
   localparam int BUF_FULL_BIT  = 16;
   localparam int BUF_EMPTY_BIT = 17;
   // measurement configuration fields
   localparam int AUTO_EN_BIT      = 0;
   localparam int THR_IRQ_EN_BIT   = 9;
   localparam int THR_FLAG_BIT     = 16;
   // fifo data word status bits
   localparam int FD_EMPTY_BIT = 30;
   localparam int FD_FULL_BIT  = 31;
   // reset values
   localparam logic [31:0] CONV_CTRL_RST = 32'h0000_0000;
   localparam logic [6:0]  TRIG_RST      = 7'h20;
   localparam logic [31:0] THRESH_RST    = 32'h0FFF_0000;
   localparam logic [31:0] INTERVAL_RST  = 32'h0000_1000;
   // timing
   localparam int CLK_MHZ        = 250;
   localparam int PULSE_US       = 2000;
   localparam int PULSE_CYCLES   = PULSE_US * CLK_MHZ;
   localparam int DIVIDER_RATIO  = 5;
   // sequences
   localparam logic [2:0] SEQ_SUPPLY  = 3'h0;
   localparam logic [2:0] SEQ_EXTRA1  = 3'h1;
   localparam logic [2:0] SEQ_EXTRA2  = 3'h2;
   localparam logic [2:0] SEQ_SCAN    = 3'h3;
   localparam logic [2:0] SEQ_THERM1  = 3'h4;
   localparam logic [2:0] SEQ_THERM2  = 3'h5;
   localparam logic [2:0] SEQ_ALL     = 3'h6;
   typedef enum logic [2:0] {
      CH_SUPPLY, CH_EXTRA1, CH_EXTRA2, CH_THERM1, CH_THERM2
   } amfc_chan_t;
   typedef struct packed {
      logic       start;
      amfc_chan_t chan;
      logic [1:0] res;
      logic       divide;
   } amfc_conv_req_t;
   typedef struct packed {
      logic        done;
      logic [11:0] code;
   } amfc_conv_rsp_t;
endpackage

/* File: design/amfc_fifo.sv */
// circular result buffer with read, write and trigger pointers
`timescale 1ns/1ps
module amfc_fifo
   import amfc_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_arst_n,
   input  wire logic          i_ce,
   input  wire logic          i_clear,
   input  wire logic [AW:0]   i_trig_level,
   input  wire logic          i_wr,
   input  wire logic [15:0]   i_wr_data,
   input  wire logic          i_rd,
   output logic [15:0]        o_rd_data,
   output logic               o_empty,
   output logic               o_full,
   output logic               o_trig_hit,
   output logic               o_first_of_set
);
   logic [15:0]   mem [DEPTH];
   logic [AW-1:0] fifo_read_pointer;
   logic [AW-1:0] fifo_write_pointer;
   logic [AW-1:0] fifo_trigger_pointer;
   logic [AW:0]   count;
   logic [AW-1:0] set_start;

   function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] a, input logic [AW:0] b);
      logic [AW:0] s;
      s = {1'b0, a} + b;
      return s[AW-1:0];
   endfunction

   wire logic [AW-1:0] trig_ptr_init = i_trig_level[AW-1:0];
   wire logic          do_rd = i_rd && (count != '0);
   wire logic          full_now = (count == (AW+1)'(DEPTH));

   assign o_empty    = (count == '0);
   assign o_full     = full_now;
   assign o_rd_data  = mem[fifo_read_pointer];
   assign o_trig_hit = i_wr && (fifo_write_pointer == fifo_trigger_pointer);
   assign o_first_of_set = do_rd && (fifo_read_pointer == set_start);

   always_ff @(posedge i_core_clk) begin
      if (i_ce && i_wr) begin
         mem[fifo_write_pointer] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fifo_read_pointer    <= AW'(1);
         fifo_write_pointer   <= AW'(1);
         fifo_trigger_pointer <= TRIG_RST[AW-1:0];
         set_start            <= AW'(1);
         count                <= '0;
      end else if (i_ce) begin
         if (i_clear) begin
            fifo_read_pointer    <= AW'(1);
            fifo_write_pointer   <= AW'(1);
            fifo_trigger_pointer <= trig_ptr_init;
            set_start            <= AW'(1);
            count                <= '0;
         end else begin
            if (i_wr) begin
               fifo_write_pointer <= wrap_add(fifo_write_pointer, (AW+1)'(1));
               if (o_trig_hit) begin
                  fifo_trigger_pointer <= wrap_add(fifo_trigger_pointer, i_trig_level);
                  set_start            <= wrap_add(fifo_write_pointer, (AW+1)'(1) - i_trig_level);
               end
            end
            if (i_wr && full_now) begin
               fifo_read_pointer <= wrap_add(fifo_read_pointer, (AW+1)'(1));
            end else if (do_rd) begin
               fifo_read_pointer <= wrap_add(fifo_read_pointer, (AW+1)'(1));
            end
            if (i_wr && !full_now && !do_rd) begin
               count <= count + (AW+1)'(1);
            end else if (!i_wr && do_rd) begin
               count <= count - (AW+1)'(1);
            end
         end
      end
   end
endmodule

/* File: design/amfc_top.sv */
// auxiliary measurement sequencer, threshold check, buffer control and axi4-lite slave
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module amfc_top
   import amfc_pkg::*;
#(
   parameter int DEPTH        = 64,
   parameter int AW           = 6,
   parameter int PULSE_LEN    = PULSE_CYCLES
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_ce,
   // axi4-lite slave
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // converter front end
   output amfc_conv_req_t   o_conv_req,
   input  amfc_conv_rsp_t   i_conv_rsp,
   output logic             o_divider_en,
   output logic             o_int_bias_en,
   output logic             o_ext_bias_en,
   // pins
   output logic             o_data_ready_irq,
   output logic             o_general_pin_one
);
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} amfc_state_t;

   logic [31:0] conv_ctrl;
   logic        buf_en, buf_cont;
   logic [AW:0] trig_level;
   logic        auto_en, thr_irq_en, thr_flag;
   logic [31:0] thresh, interval;
   logic [11:0] supply_cell_result, first_extra_result, second_extra_result;
   logic [11:0] thermal_single_result, thermal_diff_result;
   amfc_state_t state;
   logic [2:0]  step;
   logic        is_auto, paused;
   logic [31:0] tick, pulse_cnt;
   logic        aw_held, w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;

   wire logic [2:0]  conversion_sequence_select = conv_ctrl[SEQ_LSB +: 3];
   wire logic [1:0]  res_sel = conv_ctrl[RES_LSB +: 2];
   wire logic [1:0]  rmode   = conv_ctrl[RMODE_LSB +: 2];

   // decode sequence step into channel; scan order battery, extra1, extra2
   function automatic amfc_chan_t seq_chan(input logic [2:0] sel, input logic [2:0] s);
      case (sel)
         SEQ_SUPPLY: return CH_SUPPLY;
         SEQ_EXTRA1: return CH_EXTRA1;
         SEQ_EXTRA2: return CH_EXTRA2;
         SEQ_THERM1: return CH_THERM1;
         SEQ_THERM2: return CH_THERM2;
         SEQ_SCAN:   return amfc_chan_t'(s);
         SEQ_ALL:    return amfc_chan_t'(s);
         default:    return CH_SUPPLY;
      endcase
   endfunction

   function automatic logic [2:0] seq_len(input logic [2:0] sel);
      case (sel)
         SEQ_SCAN: return 3'h3;
         SEQ_ALL:  return 3'h5;
         default:  return 3'h1;
      endcase
   endfunction

   // mask the code down to the programmed resolution, unsigned, msb aligned at bit 11
   function automatic logic [11:0] res_mask(input logic [11:0] c, input logic [1:0] r);
      case (r)
         2'h1:    return {c[11:2], 2'h0};
         2'h2:    return {c[11:4], 4'h0};
         default: return c;
      endcase
   endfunction

   // write channel
   wire logic aw_ok   = aw_held || i_awvalid;
   wire logic w_ok    = w_held || i_wvalid;
   wire logic wr_fire = aw_ok && w_ok && !o_bvalid;
   wire logic [7:0]  wr_addr = aw_held ? aw_addr : i_awaddr;
   wire logic [31:0] wr_dat  = w_held ? w_data : i_wdata;
   wire logic        wr_lo   = i_wstrb[0] || w_held;
   wire logic rd_fire = i_arvalid && o_arready;
   wire logic rd_fifo = rd_fire && (i_araddr == REG_FIFO_DATA);
   wire logic rd_cfg  = rd_fire && (i_araddr == REG_MEAS_CONFIG);
   wire logic buf_clr = wr_fire && (wr_addr == REG_BUFFER_CTRL) && wr_dat[BUF_RESET_BIT];
   wire logic host_start = wr_fire && (wr_addr == REG_START);
   wire logic [6:0]  lvl_wr     = wr_dat[TRIG_LSB +: 7];
   wire logic [AW:0] new_level  = (lvl_wr == 7'h00) ? (AW+1)'(1) :
                                  (lvl_wr > 7'(DEPTH)) ? (AW+1)'(DEPTH) : (AW+1)'(lvl_wr);
   wire logic [AW:0] fifo_level = buf_clr ? new_level : trig_level;

   // fifo
   logic [15:0] f_rdata;
   logic        f_empty, f_full, f_trig, f_first;
   amfc_chan_t  cur_chan;
   wire logic   conv_done = (state == ST_WAIT) && i_conv_rsp.done;
   wire logic [11:0] code = res_mask(i_conv_rsp.code, res_sel);
   wire logic   f_wr = conv_done && buf_en;

   amfc_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo (
      .i_core_clk     (i_core_clk),
      .i_arst_n       (i_arst_n),
      .i_ce           (i_ce),
      .i_clear        (buf_clr),
      .i_trig_level   (fifo_level),
      .i_wr           (f_wr),
      .i_wr_data      ({1'b0, cur_chan, code}),
      .i_rd           (rd_fifo),
      .o_rd_data      (f_rdata),
      .o_empty        (f_empty),
      .o_full         (f_full),
      .o_trig_hit     (f_trig),
      .o_first_of_set (f_first)
   );

   // threshold check on auto results
   wire logic [11:0] thr_min = thresh[11:0];
   wire logic [11:0] thr_max = thresh[27:16];
   wire logic out_of_range = conv_done && is_auto && ((code < thr_min) || (code > thr_max));
   wire logic interval_hit = auto_en && (tick >= interval) && (interval != '0);
   wire logic auto_start = interval_hit && (state == ST_IDLE);
   wire logic buf_start  = buf_en && !paused && (state == ST_IDLE) && !buf_clr;
   wire logic go = (state == ST_IDLE) && (host_start || auto_start || buf_start);
   wire logic last_step = (step + 3'h1) == seq_len(conversion_sequence_select);

   assign cur_chan = seq_chan(conversion_sequence_select, step);

   // register read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_araddr)
         REG_CONVERTER_CTRL: rd_mux = conv_ctrl;
         REG_BUFFER_CTRL:    rd_mux = {14'h0, f_empty, f_full, 1'b0, trig_level, 5'h0,
                                       1'b0, buf_cont, buf_en};
         REG_MEAS_CONFIG:    rd_mux = {15'h0, thr_flag, 6'h0, thr_irq_en, 8'h0, auto_en};
         REG_THRESH_LIMITS:  rd_mux = thresh;
         REG_INTERVAL:       rd_mux = interval;
         REG_SUPPLY_RESULT:  rd_mux = {20'h0, supply_cell_result};
         REG_EXTRA1_RESULT:  rd_mux = {20'h0, first_extra_result};
         REG_EXTRA2_RESULT:  rd_mux = {20'h0, second_extra_result};
         REG_THERM1_RESULT:  rd_mux = {20'h0, thermal_single_result};
         REG_THERM2_RESULT:  rd_mux = {20'h0, thermal_diff_result};
         REG_FIFO_DATA:      rd_mux = {f_full, f_empty, 14'h0, f_rdata};
         default:            rd_mux = 32'h0000_0000;
      endcase
   end
   wire logic rd_hit = (i_araddr <= REG_START) && (i_araddr[1:0] == 2'h0);

   // axi handshakes
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         o_bvalid <= 1'b0;
         o_bresp  <= 2'h0;
         o_rvalid <= 1'b0;
         o_rresp  <= 2'h0;
         o_rdata  <= 32'h0000_0000;
      end else if (i_ce) begin
         if (wr_fire) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_addr <= REG_START && wr_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
         end else begin
            if (i_awvalid && o_awready) begin
               aw_held <= 1'b1;
               aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
               w_held <= 1'b1;
               w_data <= i_wstrb[0] ? i_wdata : 32'h0000_0000;
            end
            if (o_bvalid && i_bready) begin
               o_bvalid <= 1'b0;
            end
         end
         if (rd_fire) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_mux;
            o_rresp  <= rd_hit ? 2'h0 : 2'h2;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end
   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready  = !w_held && !o_bvalid;
   assign o_arready = !o_rvalid;

   // configuration registers, thresholds and interval included: a lane 0 strobe loads the whole word, held write data without it loads zero (trigger level one)
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         conv_ctrl  <= CONV_CTRL_RST;
         buf_en     <= 1'b0;
         buf_cont   <= 1'b0;
         trig_level <= TRIG_RST;
         auto_en    <= 1'b0;
         thr_irq_en <= 1'b0;
         thresh     <= THRESH_RST;
         interval   <= INTERVAL_RST;
      end else if (i_ce && wr_fire && wr_lo) begin
         case (wr_addr)
            REG_CONVERTER_CTRL: conv_ctrl <= wr_dat;
            REG_BUFFER_CTRL: begin
               buf_en     <= wr_dat[BUF_EN_BIT];
               buf_cont   <= wr_dat[BUF_CONT_BIT];
               trig_level <= new_level;
            end
            REG_MEAS_CONFIG: begin
               auto_en    <= wr_dat[AUTO_EN_BIT];
               thr_irq_en <= wr_dat[THR_IRQ_EN_BIT];
            end
            REG_THRESH_LIMITS: thresh   <= wr_dat;
            REG_INTERVAL:      interval <= wr_dat;
            default: ;
         endcase
      end
   end

   // conversion sequencer
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state      <= ST_IDLE;
         step       <= 3'h0;
         is_auto    <= 1'b0;
         o_conv_req <= '0;
         o_divider_en <= 1'b0;
         tick       <= 32'h0000_0000;
      end else if (i_ce) begin
         tick <= (interval_hit || !auto_en) ? 32'h0000_0000 : tick + 32'h0000_0001;
         case (state)
            ST_IDLE: begin
               o_conv_req.start <= 1'b0;
               if (go) begin
                  step    <= 3'h0;
                  is_auto <= auto_start;
                  state   <= ST_REQ;
               end
            end
            ST_REQ: begin
               o_conv_req.start  <= 1'b1;
               o_conv_req.chan   <= cur_chan;
               o_conv_req.res    <= res_sel;
               o_conv_req.divide <= (cur_chan == CH_SUPPLY);
               o_divider_en      <= (cur_chan == CH_SUPPLY);
               state             <= ST_WAIT;
            end
            ST_WAIT: begin
               o_conv_req.start <= 1'b0;
               if (i_conv_rsp.done) begin
                  o_divider_en <= 1'b0;
                  if (last_step) begin
                     state <= ST_IDLE;
                  end else begin
                     step  <= step + 3'h1;
                     state <= ST_REQ;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // result registers
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         supply_cell_result    <= 12'h000;
         first_extra_result    <= 12'h000;
         second_extra_result   <= 12'h000;
         thermal_single_result <= 12'h000;
         thermal_diff_result   <= 12'h000;
      end else if (i_ce && conv_done) begin
         case (cur_chan)
            CH_SUPPLY: supply_cell_result    <= code;
            CH_EXTRA1: first_extra_result    <= code;
            CH_EXTRA2: second_extra_result   <= code;
            CH_THERM1: thermal_single_result <= code;
            CH_THERM2: thermal_diff_result   <= code;
            default: ;
         endcase
      end
   end

   // buffer interrupt, threshold flag and pulse
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_data_ready_irq  <= 1'b0;
         paused            <= 1'b0;
         thr_flag          <= 1'b0;
         pulse_cnt         <= 32'h0000_0000;
         o_general_pin_one <= 1'b0;
         o_int_bias_en     <= 1'b0;
         o_ext_bias_en     <= 1'b0;
      end else if (i_ce) begin
         o_int_bias_en <= rmode == 2'h2;
         o_ext_bias_en <= rmode == 2'h1;
         if (buf_clr || !buf_en) begin
            o_data_ready_irq <= 1'b0;
            paused           <= 1'b0;
         end else if (f_wr && f_trig) begin
            o_data_ready_irq <= 1'b1;
            paused           <= !buf_cont;
         end else if (buf_cont && (f_wr || rd_fifo)) begin
            o_data_ready_irq <= 1'b0;
         end else if (!buf_cont && f_first) begin
            o_data_ready_irq <= 1'b0;
            paused           <= 1'b0;
         end
         // set wins over read-clear
         if (out_of_range) begin
            thr_flag <= 1'b1;
         end else if (rd_cfg) begin
            thr_flag <= 1'b0;
         end
         if (out_of_range && thr_irq_en) begin
            pulse_cnt         <= 32'(PULSE_LEN);
            o_general_pin_one <= 1'b1;
         end else if (pulse_cnt > 32'h0000_0001) begin
            pulse_cnt <= pulse_cnt - 32'h0000_0001;
         end else begin
            pulse_cnt         <= 32'h0000_0000;
            o_general_pin_one <= 1'b0;
         end
      end
   end
endmodule

/* File: testbench/amfc_top_chk.sv */
// port assertions for the measurement controller
`timescale 1ns/1ps
module amfc_top_chk
   import amfc_pkg::*;
(
   input wire logic           i_core_clk,
   input wire logic           i_arst_n,
   input wire logic           i_awvalid,
   input wire logic           i_wvalid,
   input wire logic           i_arvalid,
   input wire logic           o_awready,
   input wire logic           o_wready,
   input wire logic           o_bvalid,
   input wire logic           o_arready,
   input wire logic           o_rvalid,
   input wire amfc_conv_req_t o_conv_req,
   input wire amfc_conv_rsp_t i_conv_rsp,
   input wire logic           o_divider_en,
   input wire logic           o_int_bias_en,
   input wire logic           o_ext_bias_en
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   div_supply_a: assert property (o_divider_en |-> o_conv_req.chan == CH_SUPPLY)
      else $error("divider on off the supply channel");
   div_select_a: assert property (o_conv_req.start |->
      o_conv_req.divide == (o_conv_req.chan == CH_SUPPLY)) else $error("divide flag wrong");
   div_release_a: assert property (i_conv_rsp.done && o_divider_en |=> !o_divider_en)
      else $error("divider stays on after sampling");
   bias_excl_a: assert property (!(o_int_bias_en && o_ext_bias_en))
      else $error("both bias modes on");
   start_pulse_a: assert property (o_conv_req.start |=> !o_conv_req.start)
      else $error("start longer than one cycle");
   write_resp_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
      else $error("write response late");
   read_resp_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data late");
   read_block_a: assert property (o_rvalid |-> !o_arready)
      else $error("read accepted while data pending");
endmodule
bind amfc_top amfc_top_chk chk_u (.i_core_clk, .i_arst_n, .i_awvalid, .i_wvalid, .i_arvalid,
   .o_awready, .o_wready, .o_bvalid, .o_arready, .o_rvalid, .o_conv_req, .i_conv_rsp,
   .o_divider_en, .o_int_bias_en, .o_ext_bias_en);

/* File: testbench/amfc_conv_model.sv */
// converter front end: answers each start after a short or long delay
`timescale 1ns/1ps
module amfc_conv_model
   import amfc_pkg::*;
(
   input  wire logic           i_core_clk,
   input  wire logic           i_arst_n,
   input  wire amfc_conv_req_t i_req,
   output amfc_conv_rsp_t      o_rsp
);
   logic       busy;
   logic [2:0] ch;
   logic [2:0] wt;
   logic [3:0] cnt;
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy <= 1'b0;
         ch <= 3'h0;
         wt <= 3'h0;
         cnt <= 4'h0;
         o_rsp <= '0;
      end else begin
         o_rsp.done <= 1'b0;
         // code is junk outside done so a stale capture shows
         o_rsp.code <= ~o_rsp.code;
         if (i_req.start) begin
            busy <= 1'b1;
            ch <= i_req.chan;
            wt <= cnt[0] ? 3'h6 : 3'h1;
         end else if (busy && wt == 3'h0) begin
            busy <= 1'b0;
            cnt <= cnt + 4'h1;
            o_rsp.done <= 1'b1;
            o_rsp.code <= {cnt, 5'h10, ch};
         end else if (busy) begin
            wt <= wt - 3'h1;
         end
      end
   end
endmodule

/* File: testbench/amfc_top_bench.sv */
// self-checking bench for the measurement controller
`timescale 1ns/1ps
module amfc_top_bench;
   import amfc_pkg::*;
   logic           i_core_clk = 1'b0, i_arst_n = 1'b0, i_ce = 1'b1;
   logic [7:0]     i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [31:0]    i_wdata = 32'h0, o_rdata, rdv;
   logic [3:0]     i_wstrb = 4'hF;
   logic           i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic           o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]     o_bresp, o_rresp;
   amfc_conv_req_t o_conv_req;
   amfc_conv_rsp_t i_conv_rsp;
   logic           o_divider_en, o_int_bias_en, o_ext_bias_en, o_data_ready_irq;
   logic           o_general_pin_one;
   int             miscompares = 0, check_count = 0, dn = 0, k;
   always #2 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) if (i_conv_rsp.done) dn <= dn + 1;
   amfc_top #(.PULSE_LEN(20)) dut_u (.*);
   amfc_conv_model mdl_u (.i_core_clk, .i_arst_n, .i_req(o_conv_req), .o_rsp(i_conv_rsp));
   task automatic complete_run(input bit tmo);
      if (tmo) miscompares++;
      $display("miscompares %0d check_count %0d", miscompares, check_count);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkr(input logic [1:0] g, input logic [1:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t response %h expected %h", $time, g, e);
      end
   endtask
   // one write (w=1) or one read, held until the answer is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      int n;
      n = 0;
      @(posedge i_core_clk);
      {i_awaddr, i_araddr, i_wdata} <= {a, a, d};
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {w, w, w, !w, !w};
      while (n < 100 && !(w ? o_bvalid : o_rvalid)) begin
         @(posedge i_core_clk);
         n++;
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
         if (o_arready) i_arvalid <= 1'b0;
      end
      {i_bready, i_rready} <= 2'b00;
      rdv = o_rdata;
      chkr(w ? o_bresp : o_rresp, er);
      if (n >= 100) complete_run(1);
   endtask
   task automatic wait_dn(input int t);
      int n;
      n = 0;
      while (n < 2000 && dn < t) begin
         @(posedge i_core_clk);
         n++;
      end
      if (n >= 2000) complete_run(1);
   endtask
   function automatic logic [31:0] cd(input int n, input logic [2:0] c);
      return {20'h0, n[3:0], 5'h10, c};
   endfunction
   initial begin
      repeat (12) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      bus(0, REG_CONVERTER_CTRL, 32'h0, 2'h0);
      chk(rdv, CONV_CTRL_RST);
      bus(0, REG_THRESH_LIMITS, 32'h0, 2'h0);
      chk(rdv, THRESH_RST);
      bus(0, 8'h30, 32'h0, 2'h2);
      bus(1, REG_START, 32'h1, 2'h0);
      wait_dn(1);
      bus(0, REG_SUPPLY_RESULT, 32'h0, 2'h0);
      chk(rdv, cd(0, SEQ_SUPPLY));
      bus(1, REG_CONVERTER_CTRL, 32'h81, 2'h0);
      bus(1, REG_START, 32'h1, 2'h0);
      wait_dn(2);
      chk({30'h0, o_ext_bias_en, o_int_bias_en}, 32'h1);
      bus(0, REG_EXTRA1_RESULT, 32'h0, 2'h0);
      chk(rdv, cd(1, SEQ_EXTRA1));
      bus(1, REG_CONVERTER_CTRL, {29'h0, SEQ_SCAN}, 2'h0);
      bus(1, REG_START, 32'h1, 2'h0);
      wait_dn(5);
      for (int i = 0; i < 3; i++) begin
         bus(0, REG_SUPPLY_RESULT + 8'(4 * i), 32'h0, 2'h0);
         chk(rdv, cd(2 + i, 3'(i)));
      end
      // 8-bit resolution zeroes the four low bits of the code
      bus(1, REG_CONVERTER_CTRL, 32'h22, 2'h0);
      bus(1, REG_START, 32'h1, 2'h0);
      wait_dn(6);
      bus(0, REG_EXTRA2_RESULT, 32'h0, 2'h0);
      chk(rdv, cd(5, SEQ_EXTRA2) & 32'hFF0);
      // auto extra1 conversion against a zero window must trip the flag and the pin
      bus(1, REG_CONVERTER_CTRL, {29'h0, SEQ_EXTRA1}, 2'h0);
      bus(1, REG_THRESH_LIMITS, 32'h0, 2'h0);
      bus(1, REG_INTERVAL, 32'h40, 2'h0);
      bus(1, REG_MEAS_CONFIG, 32'h201, 2'h0);
      wait_dn(7);
      chk({31'h0, o_general_pin_one}, 32'h1);
      bus(1, REG_MEAS_CONFIG, 32'h0, 2'h0);
      bus(0, REG_MEAS_CONFIG, 32'h0, 2'h0);
      chk(rdv, 32'h1_0000);
      bus(0, REG_MEAS_CONFIG, 32'h0, 2'h0);
      chk(rdv, 32'h0);
      repeat (20) @(posedge i_core_clk);
      chk({31'h0, o_general_pin_one}, 32'h0);
      bus(0, REG_FIFO_DATA, 32'h0, 2'h0);
      chk(rdv & 32'h4000_0000, 32'h4000_0000);
      bus(0, REG_BUFFER_CTRL, 32'h0, 2'h0);
      chk(rdv & 32'h2_0000, 32'h2_0000);
      bus(1, REG_CONVERTER_CTRL, 32'h0, 2'h0);
      k = dn;
      bus(1, REG_BUFFER_CTRL, 32'h305, 2'h0);
      wait_dn(k + 3);
      repeat (3) @(posedge i_core_clk);
      chk({31'h0, o_data_ready_irq}, 32'h1);
      bus(0, REG_FIFO_DATA, 32'h0, 2'h0);
      chk(rdv & 32'hFFFF, cd(k, SEQ_SUPPLY));
      repeat (3) @(posedge i_core_clk);
      chk({31'h0, o_data_ready_irq}, 32'h0);
      // continuous mode: irq at the trigger write, gone at the next write
      bus(1, REG_BUFFER_CTRL, 32'h0, 2'h0);
      repeat (20) @(posedge i_core_clk);
      k = dn;
      bus(1, REG_BUFFER_CTRL, 32'h307, 2'h0);
      wait_dn(k + 3);
      chk({31'h0, o_data_ready_irq}, 32'h1);
      wait_dn(k + 4);
      chk({31'h0, o_data_ready_irq}, 32'h0);
      complete_run(0);
   end
endmodule
